// ==== smn_pkg_debounce.sv ====
// Shared constants for the setup menu navigator and its key debouncer.
package smn_pkg;

   // Menu and value geometry.
   localparam int MENU_W  = 3;
   localparam int PARAM_W = 3;
   localparam int DIGITS  = 5;
   localparam int VAL_W   = 4 * DIGITS;
   localparam int CHC_W   = 4;
   localparam int IDX_W   = MENU_W + PARAM_W;
   localparam int DEPTH   = 1 << IDX_W;

   // Main menus in their scrolling order.
   localparam logic [MENU_W-1:0] MENU_CONFIG          = 3'h0;
   localparam logic [MENU_W-1:0] MENU_FORMAT          = 3'h1;
   localparam logic [MENU_W-1:0] MENU_CALIBRATION     = 3'h2;
   localparam logic [MENU_W-1:0] MENU_SERIAL          = 3'h3;
   localparam logic [MENU_W-1:0] MENU_INPUT_ASSIGN    = 3'h4;
   localparam logic [MENU_W-1:0] MENU_FACTORY_RESTORE = 3'h5;
   localparam logic [MENU_W-1:0] MENU_FIRMWARE_ID     = 3'h6;

   // Prompt and choice counts.
   localparam logic [PARAM_W-1:0] CONFIG_PARAMS    = 3'h6;
   localparam logic [PARAM_W-1:0] OTHER_PARAMS     = 3'h2;
   localparam logic [CHC_W-1:0]   CHC_NUMERIC      = 4'h0;
   localparam logic [CHC_W-1:0]   CHC_ZERO_TRACK   = 4'h4;
   localparam logic [CHC_W-1:0]   CHC_ZERO_RANGE   = 4'h2;
   localparam logic [CHC_W-1:0]   CHC_MOTION_BAND  = 4'h7;
   localparam logic [CHC_W-1:0]   CHC_OVERLOAD     = 4'h4;
   localparam logic [CHC_W-1:0]   CHC_FILTER       = 4'h8;
   localparam logic [CHC_W-1:0]   CHC_OTHER        = 4'h2;
   localparam logic [VAL_W-1:0]   GRADS_DEFAULT    = 20'h05000;
   localparam logic [VAL_W-1:0]   LIST_DEFAULT     = 20'h00000;
   localparam logic [3:0]         BCD_MAX          = 4'h9;

   // Serial command codes and timing.
   localparam logic [1:0] CMD_KEY_RIGHT = 2'h0;
   localparam logic [1:0] CMD_KEY_ENTER = 2'h1;
   localparam logic [1:0] CMD_READ      = 2'h2;
   localparam logic [1:0] CMD_WRITE     = 2'h3;
   localparam int CLK_HZ      = 10_000_000;
   localparam int DEBOUNCE_MS = 20;
   localparam int BLINK_MS    = 250;
   localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
   localparam int BLINK_CYC    = CLK_HZ / 1000 * BLINK_MS;

   typedef enum logic [2:0] {
      ST_NORMAL  = 3'b000,
      ST_MAIN    = 3'b001,
      ST_PARAM   = 3'b011,
      ST_VALUE   = 3'b010,
      ST_DIGIT   = 3'b110,
      ST_PENDING = 3'b111
   } smn_state_t;

   function automatic logic [PARAM_W-1:0] smn_param_count(
      input logic [MENU_W-1:0] menu);
      return (menu == MENU_CONFIG) ? CONFIG_PARAMS : OTHER_PARAMS;
   endfunction

   // Zero choices marks a numeric parameter edited digit by digit.
   function automatic logic [CHC_W-1:0] smn_choice_count(
      input logic [MENU_W-1:0] menu, input logic [PARAM_W-1:0] prm);
      logic [CHC_W-1:0] c;
      c = CHC_OTHER;
      if (menu == MENU_CONFIG) begin
         case (prm)
            3'h0:    c = CHC_NUMERIC;
            3'h1:    c = CHC_ZERO_TRACK;
            3'h2:    c = CHC_ZERO_RANGE;
            3'h3:    c = CHC_MOTION_BAND;
            3'h4:    c = CHC_OVERLOAD;
            default: c = CHC_FILTER;
         endcase
      end
      return c;
   endfunction

   function automatic logic [VAL_W-1:0] smn_default(
      input logic [MENU_W-1:0] menu, input logic [PARAM_W-1:0] prm);
      return (smn_choice_count(menu, prm) == CHC_NUMERIC) ?
             GRADS_DEFAULT : LIST_DEFAULT;
   endfunction

   function automatic logic [IDX_W-1:0] smn_index(
      input logic [MENU_W-1:0] menu, input logic [PARAM_W-1:0] prm);
      return {menu, prm};
   endfunction

   function automatic logic smn_param_valid(
      input logic [MENU_W-1:0] menu, input logic [PARAM_W-1:0] prm);
      return (menu <= MENU_FIRMWARE_ID) && (prm < smn_param_count(menu));
   endfunction

endpackage

// Key debouncer.
module smn_debounce #(
   parameter int CYCLES = smn_pkg::DEBOUNCE_CYC
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   // Raw pin and debounced press
   input  wire logic pin_raw,
   output logic      press_pulse
);
   import smn_pkg::*;

   logic        sync1_reg;
   logic        sync2_reg;
   logic        stable_reg;
   logic [31:0] cnt_reg;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
      end
   end

   // A level must hold a whole window to be believed.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         stable_reg  <= 1'b0;
         cnt_reg     <= 32'h0;
         press_pulse <= 1'b0;
      end else begin
         press_pulse <= 1'b0;
         if (sync2_reg == stable_reg) begin
            cnt_reg <= 32'h0;
         end else if (cnt_reg >= 32'(CYCLES - 1)) begin
            cnt_reg     <= 32'h0;
            stable_reg  <= sync2_reg;
            press_pulse <= sync2_reg;
         end else begin
            cnt_reg <= cnt_reg + 32'h1;
         end
      end
   end

endmodule // smn_debounce

// ==== smn_navigator.sv ====
// Setup menu navigator: key handling, menu walk, digit editing, store.
//
// Notes on behaviour
// - Setup press in normal enters configuration menu.
// - Setup press in setup returns to normal.
// - Keys reach menus only in setup mode.
// - RIGHT scrolls main menus, wraps after last.
// - ENTER on main menu shows first prompt.
// - RIGHT advances to the next prompt.
// - RIGHT on last prompt climbs to menus.
// - ENTER on prompt shows its value list.
// - RIGHT scrolls values, wrapping at the end.
// - ENTER stores shown value, back to prompt.
// - First RIGHT selects leftmost digit, which blinks.
// - ENTER bumps digit; RIGHT moves selection right.
// - RIGHT past last digit stops blinking, pending.
// - ENTER while pending saves and climbs.
// - RIGHT while pending restarts at leftmost digit.
// - Serial commands emulate keys, configure, dump.
// - Serial port reads whole configuration; writes only at menu or prompt level.
module smn_navigator
   import smn_pkg::*;
#(
   parameter int DEBOUNCE_CYCLES = smn_pkg::DEBOUNCE_CYC,
   parameter int BLINK_CYCLES    = smn_pkg::BLINK_CYC
) (
   // Clock and reset
   input  wire logic                       clk_sys,
   input  wire logic                       sys_rst,
   // Operator pins
   input  wire logic                       setup_sw,
   input  wire logic                       key_right,
   input  wire logic                       key_enter,
   // Serial command port
   input  wire logic                       cmd_valid,
   input  wire logic [1:0]                 cmd_code,
   input  wire logic [smn_pkg::MENU_W-1:0] cmd_menu,
   input  wire logic [smn_pkg::PARAM_W-1:0] cmd_param,
   input  wire logic [smn_pkg::VAL_W-1:0]  cmd_data,
   output logic                            rsp_valid,
   output logic                            rsp_ok,
   output logic [smn_pkg::VAL_W-1:0]       rsp_data,
   // Display
   output logic                            setup_active,
   output logic [2:0]                      disp_level,
   output logic [smn_pkg::MENU_W-1:0]      disp_menu,
   output logic [smn_pkg::PARAM_W-1:0]     disp_param,
   output logic [smn_pkg::VAL_W-1:0]       disp_value,
   output logic [smn_pkg::DIGITS-1:0]      disp_blank,
   // Stored configuration update
   output logic                            cfg_upd_valid,
   output logic [smn_pkg::MENU_W-1:0]      cfg_upd_menu,
   output logic [smn_pkg::PARAM_W-1:0]     cfg_upd_param,
   output logic [smn_pkg::VAL_W-1:0]       cfg_upd_data
);
   import smn_pkg::*;

   localparam logic [2:0] DIG_LEFT  = 3'(DIGITS - 1);
   localparam logic [2:0] DIG_RIGHT = 3'h0;

   smn_state_t           state_reg;
   logic [MENU_W-1:0]    menu_reg;
   logic [PARAM_W-1:0]   param_reg;
   logic [VAL_W-1:0]     val_reg;
   logic [2:0]           dig_reg;
   logic [VAL_W-1:0]     store_mem [0:DEPTH-1];
   logic [31:0]          blink_cnt_reg;
   logic                 blink_phase_reg;

   logic                 setup_press;
   logic                 right_press;
   logic                 enter_press;
   logic                 right_ev;
   logic                 enter_ev;
   logic                 in_setup;
   logic                 numeric;
   logic                 save_ev;
   logic [CHC_W-1:0]     chc;
   logic [VAL_W-1:0]     stored_val;
   logic                 host_wr_ok;
   logic                 host_rd_ok;

   // One debouncer per pin.
   smn_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_deb_setup (
      .clk_sys     (clk_sys),
      .sys_rst     (sys_rst),
      .pin_raw     (setup_sw),
      .press_pulse (setup_press)
   );

   smn_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_deb_right (
      .clk_sys     (clk_sys),
      .sys_rst     (sys_rst),
      .pin_raw     (key_right),
      .press_pulse (right_press)
   );

   smn_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_deb_enter (
      .clk_sys     (clk_sys),
      .sys_rst     (sys_rst),
      .pin_raw     (key_enter),
      .press_pulse (enter_press)
   );

   // A keypad and an emulated press in one cycle merge into
   // one event.
   always_comb begin
      right_ev = right_press |
                 (cmd_valid && cmd_code == CMD_KEY_RIGHT);
      enter_ev = enter_press |
                 (cmd_valid && cmd_code == CMD_KEY_ENTER);
      in_setup = (state_reg != ST_NORMAL);
      chc      = smn_choice_count(menu_reg, param_reg);
      numeric  = (chc == CHC_NUMERIC);
      stored_val = store_mem[smn_index(menu_reg, param_reg)];
   end

   // Operator store.
   always_comb begin
      save_ev = !setup_press && enter_ev &&
                ((state_reg == ST_VALUE) || (state_reg == ST_PENDING));
   end

   // Host writes land only while nobody is mid-edit, so the operator
   // and the host never store in one cycle.
   always_comb begin
      host_rd_ok = smn_param_valid(cmd_menu, cmd_param);
      host_wr_ok = host_rd_ok &&
                   ((state_reg == ST_MAIN) || (state_reg == ST_PARAM));
   end

   // Navigation state machine.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg <= ST_NORMAL;
         menu_reg  <= MENU_CONFIG;
         param_reg <= '0;
         val_reg   <= '0;
         dig_reg   <= DIG_LEFT;
      end else if (setup_press) begin
         if (in_setup) begin
            state_reg <= ST_NORMAL;
         end else begin
            state_reg <= ST_MAIN;
            menu_reg  <= MENU_CONFIG;
            param_reg <= '0;
         end
      end else begin
         unique case (state_reg)
            ST_NORMAL: begin
               // Keys do nothing outside setup.
               state_reg <= ST_NORMAL;
            end
            ST_MAIN: begin
               if (enter_ev) begin
                  state_reg <= ST_PARAM;
                  param_reg <= '0;
               end else if (right_ev) begin
                  if (menu_reg == MENU_FIRMWARE_ID) begin
                     menu_reg <= MENU_CONFIG;
                  end else begin
                     menu_reg <= menu_reg + 3'h1;
                  end
               end
            end
            ST_PARAM: begin
               if (enter_ev) begin
                  state_reg <= ST_VALUE;
                  val_reg   <= stored_val;
                  dig_reg   <= DIG_LEFT;
               end else if (right_ev) begin
                  if (param_reg == smn_param_count(menu_reg) - 3'h1) begin
                     state_reg <= ST_MAIN;
                  end else begin
                     param_reg <= param_reg + 3'h1;
                  end
               end
            end
            ST_VALUE: begin
               if (enter_ev) begin
                  state_reg <= ST_PARAM;
               end else if (right_ev) begin
                  if (numeric) begin
                     state_reg <= ST_DIGIT;
                     dig_reg   <= DIG_LEFT;
                  end else if (val_reg[CHC_W-1:0] == chc - 4'h1) begin
                     val_reg <= '0;
                  end else begin
                     val_reg <= val_reg + VAL_W'(1);
                  end
               end
            end
            ST_DIGIT: begin
               if (enter_ev) begin
                  val_reg <= smn_bcd_inc(val_reg, dig_reg);
               end else if (right_ev) begin
                  if (dig_reg == DIG_RIGHT) begin
                     state_reg <= ST_PENDING;
                  end else begin
                     dig_reg <= dig_reg - 3'h1;
                  end
               end
            end
            ST_PENDING: begin
               if (enter_ev) begin
                  state_reg <= ST_PARAM;
               end else if (right_ev) begin
                  state_reg <= ST_DIGIT;
                  dig_reg   <= DIG_LEFT;
               end
            end
            default: begin
               state_reg <= ST_NORMAL;
            end
         endcase
      end
   end

   // Store, written by the operator or the host.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            store_mem[i] <= smn_default(MENU_W'(i >> PARAM_W),
                                        PARAM_W'(i));
         end
      end else if (save_ev) begin
         store_mem[smn_index(menu_reg, param_reg)] <= val_reg;
      end else if (cmd_valid && cmd_code == CMD_WRITE && host_wr_ok) begin
         store_mem[smn_index(cmd_menu, cmd_param)] <= cmd_data;
      end
   end

   // Store update notice.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cfg_upd_valid <= 1'b0;
         cfg_upd_menu  <= '0;
         cfg_upd_param <= '0;
         cfg_upd_data  <= '0;
      end else if (save_ev) begin
         cfg_upd_valid <= 1'b1;
         cfg_upd_menu  <= menu_reg;
         cfg_upd_param <= param_reg;
         cfg_upd_data  <= val_reg;
      end else if (cmd_valid && cmd_code == CMD_WRITE && host_wr_ok) begin
         cfg_upd_valid <= 1'b1;
         cfg_upd_menu  <= cmd_menu;
         cfg_upd_param <= cmd_param;
         cfg_upd_data  <= cmd_data;
      end else begin
         cfg_upd_valid <= 1'b0;
      end
   end

   // Every command gets one answer next cycle.
   // A read past the last prompt of a menu answers not-ok, which is how
   // a host walking the map finds the end of each list.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rsp_valid <= 1'b0;
         rsp_ok    <= 1'b0;
         rsp_data  <= '0;
      end else begin
         rsp_valid <= cmd_valid;
         if (cmd_valid) begin
            unique case (cmd_code)
               CMD_READ: begin
                  rsp_ok   <= host_rd_ok;
                  rsp_data <= host_rd_ok ?
                              store_mem[smn_index(cmd_menu, cmd_param)] :
                              '0;
               end
               CMD_WRITE: begin
                  rsp_ok   <= host_wr_ok;
                  rsp_data <= cmd_data;
               end
               default: begin
                  rsp_ok   <= in_setup;
                  rsp_data <= '0;
               end
            endcase
         end
      end
   end

   // Blink clock.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         blink_cnt_reg   <= 32'h0;
         blink_phase_reg <= 1'b0;
      end else if (blink_cnt_reg >= 32'(BLINK_CYCLES - 1)) begin
         blink_cnt_reg   <= 32'h0;
         blink_phase_reg <= ~blink_phase_reg;
      end else begin
         blink_cnt_reg <= blink_cnt_reg + 32'h1;
      end
   end

   // Display outputs.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         setup_active <= 1'b0;
         disp_level   <= ST_NORMAL;
         disp_menu    <= MENU_CONFIG;
         disp_param   <= '0;
         disp_value   <= '0;
         disp_blank   <= '0;
      end else begin
         setup_active <= in_setup;
         disp_level   <= state_reg;
         disp_menu    <= menu_reg;
         disp_param   <= param_reg;
         disp_value   <= val_reg;
         if (state_reg == ST_DIGIT && blink_phase_reg) begin
            disp_blank <= DIGITS'(1) << dig_reg;
         end else begin
            disp_blank <= '0;
         end
      end
   end

   // BCD digit increment; nine rolls to zero.
   function automatic logic [VAL_W-1:0] smn_bcd_inc(
      input logic [VAL_W-1:0] v, input logic [2:0] d);
      logic [VAL_W-1:0] r;
      r = v;
      for (int k = 0; k < DIGITS; k++) begin
         if (3'(k) == d) begin
            r[4*k +: 4] = (v[4*k +: 4] >= BCD_MAX) ? 4'h0 :
                          v[4*k +: 4] + 4'h1;
         end
      end
      return r;
   endfunction

endmodule // smn_navigator

// ==== smn_keypad_model.sv ====
// Keypad and setup switch model with contact bounce on each press.
module smn_keypad_model #(
   parameter int HOLD = 14
) (
   // Clock
   input  wire logic       clk_sys,
   // Press request: bit0 right, bit1 enter, bit2 setup
   input  wire logic [2:0] kp_req,
   // Pins and status
   output logic            key_right,
   output logic            key_enter,
   output logic            setup_sw,
   output logic            kp_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   int         cnt_reg = 0;
   logic [2:0] sel_reg = 3'h0;
   logic       high;
   always @(posedge clk_sys) begin
      if (cnt_reg == 0 && kp_req != 3'h0) begin
         sel_reg <= kp_req;
         cnt_reg <= 2 * HOLD;
      end else if (cnt_reg != 0) begin
         cnt_reg <= cnt_reg - 1;
      end
   end
   // A contact glitch must not give a second event.
   assign high = cnt_reg > HOLD && cnt_reg != 2 * HOLD - 1;
   assign {setup_sw, key_enter, key_right} = high ? sel_reg : 3'h0;
   assign kp_busy = cnt_reg != 0;
endmodule // smn_keypad_model

// ==== smn_navigator_chk.sv ====
// Port-level assertions for the setup menu navigator.
module smn_navigator_chk #(
   parameter int BLINK_CYCLES = smn_pkg::BLINK_CYC
) (
   // Clock and reset
   input wire logic                       clk_sys,
   input wire logic                       sys_rst,
   // Serial command port
   input wire logic                       cmd_valid,
   input wire logic [1:0]                 cmd_code,
   input wire logic [smn_pkg::MENU_W-1:0] cmd_menu,
   input wire logic [smn_pkg::VAL_W-1:0]  cmd_data,
   input wire logic                       rsp_valid,
   input wire logic                       rsp_ok,
   input wire logic [smn_pkg::VAL_W-1:0]  rsp_data,
   // Display and store
   input wire logic                       setup_active,
   input wire logic [2:0]                 disp_level,
   input wire logic [smn_pkg::MENU_W-1:0] disp_menu,
   input wire logic [smn_pkg::DIGITS-1:0] disp_blank,
   input wire logic                       cfg_upd_valid,
   input wire logic [smn_pkg::VAL_W-1:0]  cfg_upd_data
);
   import smn_pkg::*;
   int unsigned dark_reg;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // Digit-level cycles with no blanking.
   always_ff @(posedge clk_sys) begin
      if (sys_rst || disp_level != 3'b110 || disp_blank != '0) begin
         dark_reg <= 0;
      end else begin
         dark_reg <= dark_reg + 1;
      end
   end
   property p_answer; cmd_valid |=> rsp_valid; endproperty
   property p_no_stray; rsp_valid |-> $past(cmd_valid); endproperty
   property p_key_normal;
      cmd_valid && !cmd_code[1] |=> rsp_ok == setup_active;
   endproperty
   property p_bad_read;
      cmd_valid && cmd_code == CMD_READ && cmd_menu == 3'h7
      |=> !rsp_ok && rsp_data == '0;
   endproperty
   property p_write_upd;
      cmd_valid && cmd_code == CMD_WRITE |=> cfg_upd_valid == rsp_ok
      && (!rsp_ok || cfg_upd_data == $past(cmd_data));
   endproperty
   property p_write_lvl;
      cmd_valid && cmd_code == CMD_WRITE
      ##1 !(disp_level inside {3'b001, 3'b011}) |-> !rsp_ok;
   endproperty
   property p_enter_setup;
      $rose(setup_active)
      |-> ##[0:2] disp_level == 3'b001 && disp_menu == MENU_CONFIG;
   endproperty
   property p_leave_setup;
      $fell(setup_active) |-> ##[0:2] disp_level == 3'b000;
   endproperty
   property p_blank_one; $onehot0(disp_blank); endproperty
   property p_blank_idle;
      (disp_level != 3'b110) [*2] |-> disp_blank == '0;
   endproperty
   property p_blink; dark_reg <= 2 * BLINK_CYCLES + 2; endproperty
   a_answer: assert property (p_answer)
      else $error("no answer after command");
   a_no_stray: assert property (p_no_stray)
      else $error("answer without command");
   a_key_normal: assert property (p_key_normal)
      else $error("key accepted outside setup");
   a_bad_read: assert property (p_bad_read)
      else $error("bad read not refused");
   a_write_upd: assert property (p_write_upd)
      else $error("write and store update disagree");
   a_write_lvl: assert property (p_write_lvl)
      else $error("write accepted at wrong level");
   a_enter_setup: assert property (p_enter_setup)
      else $error("setup entry not at first menu");
   a_leave_setup: assert property (p_leave_setup)
      else $error("setup exit left level set");
   a_blank_one: assert property (p_blank_one)
      else $error("more than one digit blinks");
   a_blank_idle: assert property (p_blank_idle)
      else $error("blinking outside digit edit");
   a_blink: assert property (p_blink)
      else $error("selected digit stopped blinking");
   c_digit: cover property (disp_level == 3'b110 && disp_blank != '0);
   c_pending: cover property (disp_level == 3'b111);
   c_store: cover property (cfg_upd_valid);
   c_refuse: cover property (rsp_valid && !rsp_ok);
endmodule // smn_navigator_chk

bind smn_navigator smn_navigator_chk #(.BLINK_CYCLES(BLINK_CYCLES)) u_chk (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
   .cmd_code(cmd_code), .cmd_menu(cmd_menu), .cmd_data(cmd_data),
   .rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .rsp_data(rsp_data),
   .setup_active(setup_active), .disp_level(disp_level),
   .disp_menu(disp_menu), .disp_blank(disp_blank),
   .cfg_upd_valid(cfg_upd_valid), .cfg_upd_data(cfg_upd_data)
);

// ==== testbench.sv ====
// Self-checking testbench for the setup menu navigator.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import smn_pkg::*;
   typedef struct {logic ok; logic cd; logic [19:0] d;} smn_rsp_t;
   logic        clk_sys, sys_rst, cmd_valid, setup_sw, key_right, key_enter;
   logic        rsp_valid, rsp_ok, setup_active, cfg_upd_valid, kp_busy;
   logic [1:0]  cmd_code;
   logic [2:0]  cmd_menu, cmd_param, disp_level, disp_menu, disp_param;
   logic [2:0]  cfg_upd_menu, cfg_upd_param, kp_req;
   logic [19:0] cmd_data, rsp_data, disp_value, cfg_upd_data, wd;
   logic [4:0]  disp_blank;
   logic [25:0] exp_c;
   smn_rsp_t    exp_r;
   smn_rsp_t    rq[$];
   logic [25:0] cq[$];
   int          fail_count = 0;
   int          n_checks = 0;
   int          seed = 32'h71FB210E;
   bit          in_setup = 1'b0;

   smn_navigator #(.DEBOUNCE_CYCLES(4), .BLINK_CYCLES(4)) dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .setup_sw(setup_sw),
      .key_right(key_right), .key_enter(key_enter),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_menu(cmd_menu),
      .cmd_param(cmd_param), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
      .rsp_ok(rsp_ok), .rsp_data(rsp_data), .setup_active(setup_active),
      .disp_level(disp_level), .disp_menu(disp_menu),
      .disp_param(disp_param), .disp_value(disp_value),
      .disp_blank(disp_blank), .cfg_upd_valid(cfg_upd_valid),
      .cfg_upd_menu(cfg_upd_menu), .cfg_upd_param(cfg_upd_param),
      .cfg_upd_data(cfg_upd_data));
   smn_keypad_model #(.HOLD(14)) u_kp (
      .clk_sys(clk_sys), .kp_req(kp_req), .key_right(key_right),
      .key_enter(key_enter), .setup_sw(setup_sw), .kp_busy(kp_busy));

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(string what, logic [31:0] e, logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s expected %0h seen %0h", what, e, s);
      end
   endtask

   // Each answer and store meets the oldest note.
   always @(negedge clk_sys) begin
      if (rsp_valid === 1'b1) begin
         if (rq.size() == 0) chk("rsp_valid", 0, 1);
         else begin
            exp_r = rq.pop_front();
            chk("rsp_ok", exp_r.ok, rsp_ok);
            if (exp_r.cd) chk("rsp_data", exp_r.d, rsp_data);
         end
      end
      if (cfg_upd_valid === 1'b1) begin
         exp_c = cq.size() > 0 ? cq.pop_front() : 26'h3FFFFFF;
         chk("cfg_upd", exp_c, {cfg_upd_menu, cfg_upd_param, cfg_upd_data});
      end
   end

   task automatic cmd(logic [1:0] c, logic [2:0] m, logic [2:0] p,
                      logic [19:0] d, logic ok, logic cd, logic [19:0] ed);
      rq.push_back('{ok, cd, ed});
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_menu <= m;
      cmd_param <= p;
      cmd_data <= d;
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      cmd_data <= 20'($random(seed));
      repeat (3) @(posedge clk_sys);
   endtask

   // Key k: 0/1 serial RIGHT/ENTER, 2/3/4 keypad RIGHT/ENTER/setup.
   task automatic step(int k, logic [2:0] lv, logic [2:0] m,
                       logic [2:0] p, logic [19:0] v);
      int i;
      if (k < 2) cmd(2'(k), 3'h0, 3'h0, 20'h0, in_setup, 1'b0, 20'h0);
      else begin
         @(posedge clk_sys);
         kp_req <= 3'h1 << (k - 2);
         @(posedge clk_sys);
         kp_req <= 3'h0;
         for (i = 0; i == 0 || kp_busy === 1'b1; i++) begin
            if (i > 80) begin
               chk("kp_busy", 0, 1);
               tally_and_finish();
            end
            @(posedge clk_sys);
         end
         repeat (3) @(posedge clk_sys);
      end
      @(negedge clk_sys);
      in_setup = lv != 3'h0;
      chk("disp_level", lv, disp_level);
      chk("setup_active", in_setup, setup_active);
      if (in_setup) chk("disp_menu", m, disp_menu);
      if (lv[1]) chk("disp_param", p, disp_param);
      if (lv[2] || lv == 3'b010) chk("disp_value", v, disp_value);
   endtask

   task automatic blink(logic [4:0] b);
      bit seen = 1'b0;
      repeat (12) begin
         @(negedge clk_sys);
         if (disp_blank === b) seen = 1'b1;
      end
      chk("disp_blank", 1, seen);
   endtask

   initial begin
      sys_rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_code = 2'h0;
      cmd_menu = 3'h0;
      cmd_param = 3'h0;
      cmd_data = 20'h0;
      kp_req = 3'h0;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(negedge clk_sys);
      chk("idle", 0, {setup_active, disp_level, rsp_valid, cfg_upd_valid});
      step(0, 3'b000, 0, 0, 0);
      step(4, 3'b001, MENU_CONFIG, 0, 0);
      for (int i = 1; i <= 7; i++)
         step(i == 3 ? 2 : 0, 3'b001, 3'(i % 7), 0, 0);
      // Host reads and writes at main menu level, where both are accepted.
      cmd(CMD_READ, 3'h0, 3'h0, 20'h0, 1'b1, 1'b1, GRADS_DEFAULT);
      cmd(CMD_READ, 3'h7, 3'h0, 20'h0, 1'b0, 1'b1, 20'h0);
      wd = {19'h0, 1'($random(seed))};
      cq.push_back({3'h1, 3'h0, wd});
      cmd(CMD_WRITE, 3'h1, 3'h0, wd, 1'b1, 1'b1, wd);
      cmd(CMD_READ, 3'h1, 3'h0, 20'h0, 1'b1, 1'b1, wd);
      step(1, 3'b011, 0, 0, 0);
      for (int p = 1; p <= 5; p++) step(0, 3'b011, 0, 3'(p), 0);
      step(0, 3'b001, 0, 0, 0);
      step(3, 3'b011, 0, 0, 0);
      step(0, 3'b011, 0, 1, 0);
      step(1, 3'b010, 0, 1, 0);
      cmd(CMD_WRITE, 3'h0, 3'h1, 20'h1, 1'b0, 1'b0, 20'h0);
      for (int i = 1; i <= 5; i++) step(0, 3'b010, 0, 1, 20'(i % 4));
      cq.push_back({3'h0, 3'h1, 20'h1});
      step(1, 3'b011, 0, 1, 0);
      cmd(CMD_READ, 3'h0, 3'h1, 20'h0, 1'b1, 1'b1, 20'h1);
      for (int p = 2; p <= 5; p++) step(0, 3'b011, 0, 3'(p), 0);
      step(0, 3'b001, 0, 0, 0);
      step(1, 3'b011, 0, 0, 0);
      step(1, 3'b010, 0, 0, 20'h05000);
      step(0, 3'b110, 0, 0, 20'h05000);
      blink(5'h10);
      step(1, 3'b110, 0, 0, 20'h15000);
      step(0, 3'b110, 0, 0, 20'h15000);
      blink(5'h08);
      step(1, 3'b110, 0, 0, 20'h16000);
      for (int j = 0; j < 3; j++) step(0, 3'b110, 0, 0, 20'h16000);
      step(0, 3'b111, 0, 0, 20'h16000);
      chk("disp_blank", 0, disp_blank);
      step(0, 3'b110, 0, 0, 20'h16000);
      blink(5'h10);
      for (int j = 0; j < 4; j++) step(0, 3'b110, 0, 0, 20'h16000);
      step(0, 3'b111, 0, 0, 20'h16000);
      cq.push_back({3'h0, 3'h0, 20'h16000});
      step(1, 3'b011, 0, 0, 0);
      cmd(CMD_READ, 3'h0, 3'h0, 20'h0, 1'b1, 1'b1, 20'h16000);
      step(4, 3'b000, 0, 0, 0);
      step(2, 3'b000, 0, 0, 0);
      step(1, 3'b000, 0, 0, 0);
      chk("queues", 0, rq.size() + cq.size());
      tally_and_finish();
   end
endmodule // testbench
